// file: logic/payload_convergence_mapper.sv
// Maps user bits, bytes or T1 frames onto line payload sub-blocks
`timescale 1ns/1ps
`default_nettype none
module payload_convergence_mapper
	import subblock_map_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RST_I,
	// Session control and setup
	input wire logic ACTIVATE_I, // Pulse: latch setup, start session
	input wire logic DEACTIVATE_I, // Pulse: end session
	input wire logic [1:0] MODE_I,
	input wire logic FOUR_WIRE_I,
	input wire logic [subblock_map_pkg::SLOT_W-1:0] SLOTS_I, // Byte slots, total over both pairs; per pair in clear bit mode
	input wire logic [2:0] ZBITS_I, // Single-bit slots, clear bit mode
	// User bit stream (bit and T1 modes)
	input wire logic USER_BIT_I,
	input wire logic USER_SOF_I, // Marks a T1 framing bit
	input wire logic USER_VALID_I,
	output logic USER_READY_O,
	// User byte stream (byte mode)
	input wire logic [7:0] USER_BYTE_I,
	input wire logic USER_BYTE_VALID_I,
	output logic USER_BYTE_READY_O,
	// Line frame builder side
	input wire logic LINE_READY_I,
	output logic LINE_VALID_O,
	output logic LINE_BIT_O,
	output logic [1:0] LINE_PAIR_O, // Target pairs, one-hot or both
	output logic [subblock_map_pkg::POS_W-1:0] LINE_POS_O, // Bit position
	output logic LINE_SOB_O, // First bit of a sub-block period
	// Status
	output logic [subblock_map_pkg::POS_W-1:0] KS_O, // Payload bits per pair
	output logic CFG_ERR_O,
	output logic SESSION_ACTIVE_O
);

	// ==========================================================
	// State record
	typedef struct packed {
		state_e st; // Session state
		logic [1:0] mode; // Latched framing mode
		logic four; // Latched four-wire choice
		logic [SLOT_W-1:0] npp; // Byte slots per pair
		logic [POS_W-1:0] ks; // Payload bits per pair
		logic [POS_W-1:0] pos; // Linear position, unstructured modes
		logic [2:0] bitn; // Bit within byte slot
		logic [SLOT_W-1:0] slot; // Byte slot per pair
		logic pair; // Current pair, 0 is pair one
		logic err; // Setup refused
		logic o_valid; // Output holding a bit
		logic o_bit;
		logic [1:0] o_pair;
		logic [POS_W-1:0] o_pos;
		logic o_sob;
	} map_s;

	map_s s_reg;
	map_s s_next;

	// ==========================================================
	// Source selection
	logic byte_mode; // Bytes come through the serializer
	logic running; // Session is mapping or hunting
	logic space; // Output stage can take a bit
	logic core_ready; // Mapper can consume a source bit
	logic src_bit; // Selected source bit
	logic src_valid; // Selected source valid
	logic accept; // A source bit is consumed this cycle
	logic ser_bit; // Serializer bit
	logic ser_valid; // Serializer has a bit

	assign byte_mode = (s_reg.mode == MODE_CLR_BYTE);
	assign running = (s_reg.st == ST_HUNT) || (s_reg.st == ST_FRAME) ||
		(s_reg.st == ST_RUN);
	// Line back-pressure reaches the user through this term
	assign space = !s_reg.o_valid || LINE_READY_I;
	assign core_ready = running && space && !DEACTIVATE_I;
	assign src_bit = byte_mode ? ser_bit : USER_BIT_I;
	assign src_valid = byte_mode ? ser_valid : USER_VALID_I;
	assign accept = core_ready && src_valid;
	assign USER_READY_O = core_ready && !byte_mode;

	// Byte stream is split LSB first before mapping
	byte_lsb_serializer u_ser (
		.clk_i(CLOCK_I),
		.rst_i(RST_I),
		.enable_i(running && byte_mode),
		.byte_i(USER_BYTE_I),
		.byte_valid_i(USER_BYTE_VALID_I),
		.byte_ready_o(USER_BYTE_READY_O),
		.take_i(accept && byte_mode),
		.bit_o(ser_bit),
		.bit_valid_o(ser_valid)
	);

	// ==========================================================
	// Next state
	always_comb
	begin
		logic bad; // Setup not supported
		logic [SLOT_W-1:0] npp_new; // Slots per pair from setup
		logic [2:0] zb_new; // Single-bit slots from setup
		logic slotted; // Byte structured layout
		logic lead; // A framing bit leads each sub-block
		logic [POS_W-1:0] pos_now; // Position of the accepted bit
		bad = 1'b0;
		npp_new = SLOTS_I;
		zb_new = NO_ZBITS;
		slotted = (s_reg.mode == MODE_CLR_BYTE) || (s_reg.mode == MODE_T1_AL);
		lead = (s_reg.mode == MODE_T1_AL);
		pos_now = s_reg.pos;
		s_next = s_reg;

		// Setup check, evaluated from the live setup inputs
		case (MODE_I)
			MODE_CLR_BIT:
			begin
				// Any clear payload size within the slot range
				zb_new = ZBITS_I;
				bad = (SLOTS_I < MIN_SLOTS) || (SLOTS_I > MAX_CLR_SLOTS);
			end
			MODE_CLR_BYTE:
			begin
				if (FOUR_WIRE_I)
				begin
					// Total split evenly over two pairs
					npp_new = SLOTS_I >> 1;
					bad = SLOTS_I[0] || (SLOTS_I < MIN_SLOTS_4W) ||
						(SLOTS_I > MAX_BYTE_4W);
				end
				else
				begin
					bad = (SLOTS_I < MIN_SLOTS) || (SLOTS_I > MAX_BYTE_2W);
				end
			end
			MODE_T1_UNAL:
			begin
				// Fixed layout, slot input ignored
				zb_new = T1_ZBITS;
				npp_new = T1_SLOTS;
				bad = FOUR_WIRE_I;
			end
			MODE_T1_AL:
			begin
				zb_new = T1_ZBITS;
				if (FOUR_WIRE_I)
				begin
					// Half the time slots ride on each pair
					npp_new = SLOTS_I >> 1;
					bad = SLOTS_I[0] || (SLOTS_I < MIN_SLOTS_4W) ||
						(SLOTS_I > T1_SLOTS);
				end
				else
				begin
					bad = (SLOTS_I < MIN_SLOTS) || (SLOTS_I > T1_SLOTS);
				end
			end
			default:
			begin
				bad = 1'b1;
			end
		endcase

		// Position of the current bit in its sub-block
		if (slotted)
		begin
			pos_now = POS_W'(lead) + POS_W'({s_reg.slot, 3'h0}) +
				POS_W'(s_reg.bitn);
		end

		// Output stage drains when the builder takes the bit
		if (LINE_READY_I)
		begin
			s_next.o_valid = 1'b0;
		end

		case (s_reg.st)
			ST_IDLE:
			begin
				// Setup is frozen here for the whole session
				if (ACTIVATE_I)
				begin
					s_next.mode = MODE_I;
					s_next.four = FOUR_WIRE_I;
					s_next.npp = npp_new;
					s_next.ks = POS_W'(zb_new) + POS_W'({npp_new, 3'h0});
					s_next.pos = '0;
					s_next.bitn = 3'h0;
					s_next.slot = '0;
					s_next.pair = 1'b0;
					s_next.err = bad;
					if (bad)
					begin
						s_next.st = ST_FAULT;
					end
					else if (MODE_I == MODE_T1_AL)
					begin
						s_next.st = ST_HUNT;
					end
					else
					begin
						s_next.st = ST_RUN;
					end
				end
			end
			ST_HUNT:
			begin
				// Bits before the first framing bit are dropped
				if (accept && USER_SOF_I)
				begin
					s_next.o_valid = 1'b1;
					s_next.o_bit = src_bit;
					s_next.o_pos = '0;
					s_next.o_pair = s_reg.four ? PAIR_BOTH : PAIR_ONE;
					s_next.o_sob = 1'b1;
					s_next.st = ST_RUN;
				end
			end
			ST_FRAME:
			begin
				// Locked clocks put the framing bit here every time
				if (accept)
				begin
					s_next.o_valid = 1'b1;
					s_next.o_bit = src_bit;
					s_next.o_pos = '0;
					s_next.o_pair = s_reg.four ? PAIR_BOTH : PAIR_ONE;
					s_next.o_sob = 1'b1;
					s_next.st = ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (accept)
				begin
					// Bits leave in arrival order, only tagged
					s_next.o_valid = 1'b1;
					s_next.o_bit = src_bit;
					s_next.o_pos = pos_now;
					s_next.o_pair = s_reg.pair ? PAIR_TWO : PAIR_ONE;
					s_next.o_sob = (pos_now == '0) && !s_reg.pair;
					if (slotted)
					begin
						// Byte slots, alternating pairs per byte in four-wire
						s_next.bitn = s_reg.bitn + 3'h1;
						if (s_reg.bitn == LAST_BIT)
						begin
							s_next.bitn = 3'h0;
							if (s_reg.four && !s_reg.pair)
							begin
								s_next.pair = 1'b1;
							end
							else
							begin
								s_next.pair = 1'b0;
								if (s_reg.slot == s_reg.npp - 7'h01)
								begin
									s_next.slot = '0;
									// Aligned frames restart with a framing bit
									s_next.st = lead ? ST_FRAME : ST_RUN;
								end
								else
								begin
									s_next.slot = s_reg.slot + 7'h01;
								end
							end
						end
					end
					else
					begin
						// Contiguous runs; unaligned T1 uses the same path
						if (s_reg.pos == s_reg.ks - 9'h001)
						begin
							s_next.pos = '0;
							s_next.pair = s_reg.four && !s_reg.pair;
						end
						else
						begin
							s_next.pos = s_reg.pos + 9'h001;
						end
					end
				end
			end
			ST_FAULT:
			begin
				// Nothing is mapped until the session is torn down
				s_next.o_valid = 1'b0;
			end
			default:
			begin
				s_next.st = ST_IDLE;
			end
		endcase

		// Ending the session discards any pending bit
		if (DEACTIVATE_I)
		begin
			s_next.st = ST_IDLE;
			s_next.err = 1'b0;
			s_next.o_valid = 1'b0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ==========================================================
	// Outputs, all from the state record
	assign LINE_VALID_O = s_reg.o_valid;
	assign LINE_BIT_O = s_reg.o_bit;
	assign LINE_PAIR_O = s_reg.o_pair;
	assign LINE_POS_O = s_reg.o_pos;
	assign LINE_SOB_O = s_reg.o_sob;
	assign KS_O = s_reg.ks;
	assign CFG_ERR_O = s_reg.err;
	assign SESSION_ACTIVE_O = running;

endmodule : payload_convergence_mapper
`default_nettype wire

// file: logic/subblock_map_pkg.sv
// Constants and types shared by the payload sub-block mapper files
`default_nettype none
package subblock_map_pkg;

	// ==========================================================
	// Widths
	localparam int SLOT_W = 7; // Byte slot count width
	localparam int POS_W = 9; // Bit position within a sub-block

	// ==========================================================
	// Framing modes
	localparam logic [1:0] MODE_CLR_BIT = 2'h0; // Clear channel bit stream
	localparam logic [1:0] MODE_CLR_BYTE = 2'h1; // Clear channel bytes
	localparam logic [1:0] MODE_T1_UNAL = 2'h2; // Unaligned T1
	localparam logic [1:0] MODE_T1_AL = 2'h3; // Aligned full or partial T1
	// Unframed 2M leased stream is plain clear channel bits
	localparam logic [1:0] MODE_UNSTRUCTURED_2M_LEASED_STREAM = MODE_CLR_BIT;

	// ==========================================================
	// Slot limits and fixed layouts
	localparam logic [SLOT_W-1:0] MIN_SLOTS = 7'h03; // Least slots per pair
	localparam logic [SLOT_W-1:0] MIN_SLOTS_4W = 7'h06; // Least total, two pairs
	localparam logic [SLOT_W-1:0] MAX_CLR_SLOTS = 7'h24; // Clear channel limit
	localparam logic [SLOT_W-1:0] MAX_BYTE_2W = 7'h23; // Byte mode, one pair
	localparam logic [SLOT_W-1:0] MAX_BYTE_4W = 7'h48; // Byte mode total, two pairs
	localparam logic [SLOT_W-1:0] T1_SLOTS = 7'h18; // Full T1 time slots
	localparam logic [2:0] T1_ZBITS = 3'h1; // One framing bit slot
	localparam logic [2:0] NO_ZBITS = 3'h0; // No single-bit slots
	localparam logic [2:0] LAST_BIT = 3'h7; // Last bit of a byte slot
	localparam logic [3:0] BYTE_LEN = 4'h8; // Bits per byte

	// ==========================================================
	// Pair masks on the line side
	localparam logic [1:0] PAIR_ONE = 2'h1;
	localparam logic [1:0] PAIR_TWO = 2'h2;
	localparam logic [1:0] PAIR_BOTH = 2'h3;

	// ==========================================================
	// Mapper states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01, // No session
		ST_HUNT = 5'h02, // Waiting for first T1 framing bit
		ST_FRAME = 5'h04, // Next bit is a framing bit
		ST_RUN = 5'h08, // Mapping payload bits
		ST_FAULT = 5'h10 // Bad setup, waits for deactivation
	} state_e;

endpackage : subblock_map_pkg
`default_nettype wire

// file: logic/byte_lsb_serializer.sv
// Byte to bit serializer, least significant bit first
`timescale 1ns/1ps
`default_nettype none
module byte_lsb_serializer
	import subblock_map_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i, // Byte mode session running
	input wire logic [7:0] byte_i,
	input wire logic byte_valid_i,
	output logic byte_ready_o,
	input wire logic take_i, // Mapper consumes bit_o
	output logic bit_o,
	output logic bit_valid_o
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] sh; // Bits still to send, next in bit 0
		logic [3:0] cnt; // Bits remaining
	} ser_s;

	ser_s s_reg;
	ser_s s_next;

	// Accept a new byte when empty or the last bit leaves now
	assign byte_ready_o = enable_i && ((s_reg.cnt == 4'h0) ||
		((s_reg.cnt == 4'h1) && take_i));
	assign bit_o = s_reg.sh[0];
	assign bit_valid_o = (s_reg.cnt != 4'h0);

	// ==========================================================
	// Next state
	always_comb
	begin
		s_next = s_reg;
		// Shift out the low bit first
		if (take_i && bit_valid_o)
		begin
			s_next.sh = {1'b0, s_reg.sh[7:1]};
			s_next.cnt = s_reg.cnt - 4'h1;
		end
		// Fresh byte lands with its LSB ready to go
		if (byte_ready_o && byte_valid_i)
		begin
			s_next.sh = byte_i;
			s_next.cnt = BYTE_LEN;
		end
		// Leftover bits are dropped when the session ends
		if (!enable_i)
		begin
			s_next.cnt = 4'h0;
		end
	end

	// Register the state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

endmodule : byte_lsb_serializer
`default_nettype wire

// file: tb/line_builder_model.sv
// Line frame builder model that takes mapped bits promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module line_builder_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i, // Accept one cycle in four
	output logic ready_o
);
	logic [1:0] phase_reg; // Free-running stall phase
	// ==========================================================
	// Ready pattern, free of valid so stalls also hit mid-run
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			phase_reg <= 2'h0;
			ready_o <= 1'b0;
		end
		else
		begin
			phase_reg <= phase_reg + 2'h1;
			ready_o <= !slow_i || (phase_reg == 2'h3);
		end
	end
endmodule : line_builder_model
`default_nettype wire

// file: tb/payload_mapper_asserts.sv
// Concurrent checks on the payload sub-block mapper ports
`timescale 1ns/1ps
`default_nettype none
module mapper_check
	import subblock_map_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic ACTIVATE_I,
	input wire logic DEACTIVATE_I,
	input wire logic [1:0] MODE_I,
	input wire logic FOUR_WIRE_I,
	input wire logic [subblock_map_pkg::SLOT_W-1:0] SLOTS_I,
	input wire logic [2:0] ZBITS_I,
	input wire logic USER_BIT_I,
	input wire logic USER_VALID_I,
	input wire logic USER_READY_O,
	input wire logic LINE_READY_I,
	input wire logic LINE_VALID_O,
	input wire logic LINE_BIT_O,
	input wire logic [1:0] LINE_PAIR_O,
	input wire logic [subblock_map_pkg::POS_W-1:0] LINE_POS_O,
	input wire logic LINE_SOB_O,
	input wire logic [subblock_map_pkg::POS_W-1:0] KS_O,
	input wire logic CFG_ERR_O,
	input wire logic SESSION_ACTIVE_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);
	logic [1:0] mode_reg; // Mode taken at the last idle activation
	// ==========================================================
	// Mode copy; aligned T1 hunts and drops bits, so it is left out below
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
			mode_reg <= MODE_CLR_BIT;
		else if (ACTIVATE_I && !SESSION_ACTIVE_O && !CFG_ERR_O)
			mode_reg <= MODE_I;
	end
	// Activation that the mapper takes
	sequence idle_act_s;
		ACTIVATE_I && !SESSION_ACTIVE_O && !CFG_ERR_O && !DEACTIVATE_I;
	endsequence
	// ==========================================================
	// Line side
	hold_stall_a: assert property (LINE_VALID_O && !LINE_READY_I && !DEACTIVATE_I |=>
		LINE_VALID_O && $stable({LINE_BIT_O, LINE_PAIR_O, LINE_POS_O})) else $error("stalled bit changed");
	bit_take_a: assert property (USER_VALID_I && USER_READY_O && mode_reg != MODE_T1_AL |=>
		LINE_VALID_O && LINE_BIT_O == $past(USER_BIT_I)) else $error("taken bit not presented");
	sob_pos_a: assert property (LINE_VALID_O && LINE_PAIR_O[0] |->
		LINE_SOB_O == (LINE_POS_O == 9'h000)) else $error("sub-block start misplaced");
	pos_range_a: assert property (LINE_VALID_O |-> LINE_POS_O < KS_O)
		else $error("position beyond payload size");
	// ==========================================================
	// Setup and session
	unal_four_a: assert property (idle_act_s ##0 (MODE_I == MODE_T1_UNAL && FOUR_WIRE_I) |=>
		CFG_ERR_O && !SESSION_ACTIVE_O) else $error("four-wire unaligned accepted");
	odd_four_a: assert property (idle_act_s ##0 (FOUR_WIRE_I && MODE_I != MODE_CLR_BIT && SLOTS_I[0])
		|=> CFG_ERR_O) else $error("odd four-wire slot total accepted");
	unal_ks_a: assert property (idle_act_s ##0 (MODE_I == MODE_T1_UNAL && !FOUR_WIRE_I) |=>
		SESSION_ACTIVE_O && KS_O == 9'h0c1) else $error("unaligned payload size wrong");
	clr_ks_a: assert property (idle_act_s ##0 (MODE_I == MODE_CLR_BIT && !FOUR_WIRE_I &&
		SLOTS_I inside {[7'h03:7'h24]}) |=> KS_O == 9'($past(ZBITS_I)) + 9'($past(SLOTS_I)) * 9'h008)
		else $error("clear payload size wrong");
	deact_a: assert property (DEACTIVATE_I |=> !SESSION_ACTIVE_O && !CFG_ERR_O && !USER_READY_O)
		else $error("session survived deactivation");
	start_a: assert property ($rose(SESSION_ACTIVE_O) |-> $past(ACTIVATE_I))
		else $error("session began without activation");
endmodule : mapper_check
bind payload_convergence_mapper mapper_check check_i (.CLOCK_I, .RST_I, .ACTIVATE_I,
	.DEACTIVATE_I, .MODE_I, .FOUR_WIRE_I, .SLOTS_I, .ZBITS_I, .USER_BIT_I, .USER_VALID_I,
	.USER_READY_O, .LINE_READY_I, .LINE_VALID_O, .LINE_BIT_O, .LINE_PAIR_O, .LINE_POS_O,
	.LINE_SOB_O, .KS_O, .CFG_ERR_O, .SESSION_ACTIVE_O);
`default_nettype wire

// file: tb/payload_convergence_mapper_tb_top.sv
// Self-checking testbench for the payload sub-block mapper
`timescale 1ns/1ps
`default_nettype none
module payload_convergence_mapper_tb_top;
	import subblock_map_pkg::*;
	logic CLOCK_I, RST_I, ACTIVATE_I, DEACTIVATE_I, FOUR_WIRE_I, LINE_READY_I;
	logic USER_BIT_I, USER_SOF_I, USER_VALID_I, USER_BYTE_VALID_I, slow;
	logic [1:0] MODE_I;
	logic [SLOT_W-1:0] SLOTS_I;
	logic [2:0] ZBITS_I;
	logic [7:0] USER_BYTE_I;
	logic USER_READY_O, USER_BYTE_READY_O, LINE_VALID_O, LINE_BIT_O, LINE_SOB_O;
	logic CFG_ERR_O, SESSION_ACTIVE_O;
	logic [1:0] LINE_PAIR_O;
	logic [POS_W-1:0] LINE_POS_O, KS_O;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0; // Cycles since start, for the hang limit
	logic [12:0] exp_q[$], got_q[$]; // Packed {sob, pair, pos, bit}
	payload_convergence_mapper dut (.CLOCK_I, .RST_I, .ACTIVATE_I, .DEACTIVATE_I, .MODE_I,
		.FOUR_WIRE_I, .SLOTS_I, .ZBITS_I, .USER_BIT_I, .USER_SOF_I, .USER_VALID_I,
		.USER_READY_O, .USER_BYTE_I, .USER_BYTE_VALID_I, .USER_BYTE_READY_O, .LINE_READY_I,
		.LINE_VALID_O, .LINE_BIT_O, .LINE_PAIR_O, .LINE_POS_O, .LINE_SOB_O, .KS_O,
		.CFG_ERR_O, .SESSION_ACTIVE_O);
	line_builder_model line_i (.clk_i(CLOCK_I), .rst_i(RST_I), .slow_i(slow),
		.ready_o(LINE_READY_I));
	// ==========================================================
	// Clock, capture of accepted line bits, hang limit
	always #4 CLOCK_I = ~CLOCK_I;
	always @(posedge CLOCK_I)
	begin
		cyc++;
		if (LINE_VALID_O === 1'b1 && LINE_READY_I === 1'b1)
			got_q.push_back({LINE_SOB_O, LINE_PAIR_O, LINE_POS_O, LINE_BIT_O});
		if (cyc == 5000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	// ==========================================================
	// Helpers
	function automatic logic [12:0] pk(input logic s, input logic [1:0] p, input int pos,
		input logic b);
		return {s, p, pos[8:0], b};
	endfunction : pk
	// Irregular bit pattern so a shift or swap shows
	function automatic logic pat(input int i);
		return ((i * 13) % 7) < 3;
	endfunction : pat
	task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic act(input logic [1:0] m, input logic f, input int s, input logic [2:0] z,
		input logic err, input int ks);
		MODE_I <= m;
		FOUR_WIRE_I <= f;
		SLOTS_I <= 7'(s);
		ZBITS_I <= z;
		ACTIVATE_I <= 1'b1;
		@(posedge CLOCK_I);
		ACTIVATE_I <= 1'b0;
		#1;
		chk("cfg_err", 13'(CFG_ERR_O), 13'(err));
		chk("active", 13'(SESSION_ACTIVE_O), 13'(!err));
		if (!err)
			chk("ks", 13'(KS_O), 13'(ks));
		@(posedge CLOCK_I);
	endtask : act
	task automatic deact();
		DEACTIVATE_I <= 1'b1;
		@(posedge CLOCK_I);
		DEACTIVATE_I <= 1'b0;
		#1;
		chk("stopped", 13'({SESSION_ACTIVE_O, CFG_ERR_O}), 13'h0);
		@(posedge CLOCK_I);
	endtask : deact
	// Setup tried from idle, then closed again
	task automatic tryc(input logic [1:0] m, input logic f, input int s, input logic err,
		input int ks);
		act(m, f, s, 3'h0, err, ks);
		deact();
	endtask : tryc
	// Valid stays up; the caller lowers it after the last bit
	task automatic send_bit(input logic b, input logic s);
		USER_BIT_I <= b;
		USER_SOF_I <= s;
		USER_VALID_I <= 1'b1;
		do @(posedge CLOCK_I); while (USER_READY_O !== 1'b1);
	endtask : send_bit
	// Six bytes, three slots per pair, odd bytes on pair two in four-wire
	task automatic run_bytes(input logic f);
		logic [7:0] v;
		logic [1:0] pr;
		int pos;
		for (int j = 0; j < 6; j++)
		begin
			v = 8'(j * 53 + 17);
			USER_BYTE_I <= v;
			USER_BYTE_VALID_I <= 1'b1;
			do @(posedge CLOCK_I); while (USER_BYTE_READY_O !== 1'b1);
			pr = (f && j % 2 == 1) ? PAIR_TWO : PAIR_ONE;
			pos = 8 * (f ? (j / 2) % 3 : j % 3);
			for (int b = 0; b < 8; b++)
				exp_q.push_back(pk(pos + b == 0 && pr == PAIR_ONE, pr, pos + b, v[b]));
		end
		USER_BYTE_VALID_I <= 1'b0;
	endtask : run_bytes
	// Lets the line drain, compares in order, closes the session
	task automatic drain(input string name);
		repeat (48) @(posedge CLOCK_I);
		chk("count", 13'(got_q.size()), 13'(exp_q.size()));
		while (exp_q.size() != 0 && got_q.size() != 0)
			chk(name, got_q.pop_front(), exp_q.pop_front());
		// Leftovers of a short or long run must not leak into the next test
		exp_q.delete();
		got_q.delete();
		deact();
		$display("Test %s done", name);
	endtask : drain
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// ==========================================================
	// Main sequence
	initial
	begin
		{CLOCK_I, ACTIVATE_I, DEACTIVATE_I, FOUR_WIRE_I, USER_BIT_I, USER_SOF_I} = '0;
		{USER_VALID_I, USER_BYTE_VALID_I, slow, MODE_I, SLOTS_I, ZBITS_I, USER_BYTE_I} = '0;
		RST_I = 1'b1;
		repeat (3) @(posedge CLOCK_I);
		RST_I <= 1'b0;
		@(posedge CLOCK_I);
		// Clear bits, two-wire, stalling line, one single-bit slot
		slow <= 1'b1;
		act(MODE_CLR_BIT, 1'b0, 3, 3'h1, 1'b0, 25);
		for (int i = 0; i < 60; i++)
		begin
			send_bit(pat(i), 1'b0);
			exp_q.push_back(pk(i % 25 == 0, PAIR_ONE, i % 25, pat(i)));
		end
		USER_VALID_I <= 1'b0;
		act(MODE_CLR_BYTE, 1'b1, 7, 3'h0, 1'b0, 25);
		drain("clear_2w");
		// Unframed leased stream, four-wire, back to back
		slow <= 1'b0;
		act(MODE_UNSTRUCTURED_2M_LEASED_STREAM, 1'b1, 3, 3'h0, 1'b0, 24);
		for (int i = 0; i < 96; i++)
		begin
			send_bit(pat(i), 1'b0);
			exp_q.push_back(pk(i % 48 == 0, (i / 24) % 2 == 0 ? PAIR_ONE : PAIR_TWO, i % 24,
				pat(i)));
		end
		USER_VALID_I <= 1'b0;
		drain("clear_4w");
		// Byte mode, two-wire with stalls, then four-wire
		slow <= 1'b1;
		act(MODE_CLR_BYTE, 1'b0, 3, 3'h0, 1'b0, 24);
		run_bytes(1'b0);
		drain("bytes_2w");
		slow <= 1'b0;
		act(MODE_CLR_BYTE, 1'b1, 6, 3'h0, 1'b0, 24);
		run_bytes(1'b1);
		drain("bytes_4w");
		// Unaligned T1, two-wire, one bit plus 24 bytes, past one wrap
		act(MODE_T1_UNAL, 1'b0, 0, 3'h0, 1'b0, 193);
		for (int i = 0; i < 200; i++)
		begin
			send_bit(pat(i), 1'b0);
			exp_q.push_back(pk(i % 193 == 0, PAIR_ONE, i % 193, pat(i)));
		end
		USER_VALID_I <= 1'b0;
		drain("t1_unaligned");
		// Aligned T1 four-wire, locked frames after two stray bits
		act(MODE_T1_AL, 1'b1, 6, 3'h0, 1'b0, 25);
		send_bit(1'b1, 1'b0);
		send_bit(1'b0, 1'b0);
		for (int f = 0; f < 2; f++)
		begin
			send_bit(pat(f), 1'b1);
			exp_q.push_back(pk(1'b1, PAIR_BOTH, 0, pat(f)));
			for (int k = 0; k < 48; k++)
			begin
				send_bit(pat(k + f), 1'b0);
				exp_q.push_back(pk(1'b0, (k / 8) % 2 == 0 ? PAIR_ONE : PAIR_TWO,
					1 + 8 * (k / 16) + k % 8, pat(k + f)));
			end
		end
		USER_VALID_I <= 1'b0;
		drain("t1_aligned_4w");
		// Setup limits, accepted and refused
		tryc(MODE_CLR_BYTE, 1'b1, 7, 1'b1, 0);
		tryc(MODE_CLR_BYTE, 1'b1, 72, 1'b0, 288);
		tryc(MODE_CLR_BYTE, 1'b0, 36, 1'b1, 0);
		tryc(MODE_CLR_BYTE, 1'b0, 2, 1'b1, 0);
		tryc(MODE_T1_UNAL, 1'b1, 24, 1'b1, 0);
		tryc(MODE_T1_UNAL, 1'b0, 0, 1'b0, 193);
		tryc(MODE_T1_AL, 1'b1, 7, 1'b1, 0);
		tryc(MODE_T1_AL, 1'b1, 24, 1'b0, 97);
		tryc(MODE_T1_AL, 1'b0, 25, 1'b1, 0);
		tryc(MODE_T1_AL, 1'b0, 24, 1'b0, 193);
		tryc(MODE_T1_AL, 1'b0, 3, 1'b0, 25);
		tryc(MODE_CLR_BIT, 1'b0, 37, 1'b1, 0);
		$display("Test setup_limits done");
		give_verdict();
	end
endmodule : payload_convergence_mapper_tb_top
`default_nettype wire
